// >>> core/vsu_pkg.sv
package vsu_pkg;

    // ****************************************************************
    // Clock rate and timing.
    // ****************************************************************
    localparam int CLK_HZ = 20000000; // System clock rate in hertz.
    localparam int HOLD_FAST_S = 3; // Hold time before fast stepping, seconds.
    localparam int HOLD_FAST_CYC = HOLD_FAST_S * CLK_HZ; // Hold time in cycles.
    localparam int BLINK_MS = 250; // Half period of a flashing light, milliseconds.
    localparam int BLINK_CYC = (BLINK_MS * (CLK_HZ / 1000)); // Blink half period in cycles.
    localparam int PULSE_MS = 500; // Length of a momentary light effect, milliseconds.
    localparam int PULSE_CYC = (PULSE_MS * (CLK_HZ / 1000)); // Momentary effect length in cycles.

    // ****************************************************************
    // Current loop input, in microamps.
    // ****************************************************************
    localparam logic [15:0] MA_HIGH_UA = 16'h4E20; // 20.00 mA set-maximum target.
    localparam logic [15:0] MA_LOW_UA = 16'h0FA0; // 4.00 mA set-minimum target.
    localparam logic [15:0] MA_TOL_UA = 16'h0096; // 0.15 mA acceptance tolerance.
    localparam logic [15:0] MA_LOS_UA = 16'h0032; // 0.05 mA loss-of-signal threshold.

    // ****************************************************************
    // Positions, in tenths of a degree.
    // ****************************************************************
    localparam logic [11:0] STEP_FINE = 12'h001; // 0.1 degree step.
    localparam logic [11:0] STEP_FAST = 12'h005; // 0.5 degree step.
    localparam logic [11:0] TRAVEL_MAX = 12'h050; // 8 degree travel bound.
    localparam logic [11:0] POS_MIN_RST = 12'h000; // Reset value of index 0.
    localparam logic [11:0] POS_MAX_RST = 12'h384; // Reset value of index 9, 90 degrees.
    localparam int IDX_MAX = 9; // Highest position index.
    localparam logic [15:0] PASSCODE = 16'h1234; // Stored code, arbitrary value.

    // ****************************************************************
    // Commands and modes.
    // ****************************************************************
    typedef enum logic [1:0] {
        CMD_SET_MAX = 2'b00,
        CMD_SET_MIN = 2'b01,
        CMD_UNLOCK = 2'b10,
        CMD_NONE = 2'b11
    } vsu_cmd_t;

    typedef enum logic [1:0] {
        ADJ_INDEX = 2'b00,
        ADJ_ADJUST = 2'b01,
        ADJ_STANDBY = 2'b10
    } vsu_adj_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_CODE = 2'b10
    } vsu_state_t;

    // Panel inputs after synchronisation.
    typedef struct packed {
        logic up;
        logic down;
        logic enter;
        logic go;
        logic run_sw;
    } vsu_panel_t;

    // Indicator outputs.
    typedef struct packed {
        logic [9:0] index_led;
        logic manual_led;
        logic run_led;
        logic alarm_led;
        logic set_a_led;
    } vsu_lights_t;

endpackage

// >>> core/vsu_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RQ1) Set-max accepted only near 20 mA.
// (RQ2) Rejected set-max flashes numbered lights briefly.
// (RQ3) Setup mode flashes manual, run, index 9.
// (RQ4) Adjust setting: each press moves 0.1 degree.
// (RQ5) Held over 3 s: 0.5 degree steps.
// (RQ6) Confirm stores position, blanks index and A light.
// (RQ7) Travel limited to 8 degrees from stored.
// (RQ8) Reaching bound holds all index lights on briefly.
// (RQ9) Input leaving 20 mA inhibits positioning.
// (RQ10) Completion rebuilds linear ramp min to max.
// (RQ11) Set-min accepted only near 4 mA.
// (RQ12) Set-min adjusts index 0 identically.
// (RQ13) Alarm light flashes while locked.
// (RQ14) Unlock while unlocked flashes numbered lights.
// (RQ15) Operator enters four digits with Enter.
// (RQ16) Correct code unlocks, alarm stops flashing.
// (RQ17) Run position re-locks the unit.
// (RQ18) Index setting inhibits motion, flashes index lights.
// (RQ19) Below 0.05 mA inhibits, index lights off.
// (RQ20) Wrong code keeps unit locked.
module vsu_ctrl #(
    parameter int HOLD_CYC = vsu_pkg::HOLD_FAST_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic [15:0] LOOP_UA,
    input wire logic CMD_GO,
    input wire logic [1:0] CMD_SEL,
    input wire logic [1:0] ADJUST_SETTING,
    input wire logic STEP_UP,
    input wire logic STEP_DOWN,
    input wire logic ENTER_BTN,
    input wire logic RUN_SW,
    input wire logic OTHER_ALARM,
    output logic [11:0] VALVE_POS,
    output logic POS_INHIBIT,
    output logic [9:0] INDEX_LED,
    output logic MANUAL_LED,
    output logic RUN_LED,
    output logic ALARM_LED,
    output logic SET_A_LED,
    output logic LOCKED,
    output logic [119:0] RAMP_TABLE
);

    // ****************************************************************
    // State types.
    // ****************************************************************

    // Momentary effect currently shown on the lights.
    typedef enum logic [1:0] {
        FX_NONE = 2'b00,
        FX_NUMBERED = 2'b01,
        FX_ACK = 2'b10,
        FX_ALL_ON = 2'b11
    } vsu_fx_t;

    // All registered state of this block except the reset release flops.
    typedef struct packed {
        vsu_pkg::vsu_panel_t s1;
        vsu_pkg::vsu_panel_t s2;
        vsu_pkg::vsu_panel_t prev;
        logic [15:0] ua1;
        logic [15:0] ua2;
        logic [1:0] sel1;
        logic [1:0] sel2;
        logic [1:0] adj1;
        logic [1:0] adj2;
        vsu_pkg::vsu_state_t st;
        logic hi_side;
        logic locked;
        logic [11:0] pos_min;
        logic [11:0] pos_max;
        logic [11:0] base;
        logic [11:0] pos;
        logic [31:0] hold_cnt;
        logic [23:0] blink_cnt;
        logic blink;
        logic [23:0] fx_cnt;
        vsu_fx_t fx;
        logic [1:0] digit_n;
        logic [3:0] digit;
        logic [15:0] code;
        logic [119:0] ramp;
        logic [11:0] valve;
    } vsu_regs_t;

    logic rst_a_ff; // First reset release stage.
    logic rst_b_ff; // Synchronised reset, active low.
    vsu_regs_t r_ff; // Registered state.
    vsu_regs_t nxt_r; // Next state.

    // ****************************************************************
    // Reset release.
    // ****************************************************************

    // Assert at once, release after two edges.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************

    // Whole interpreter: inputs, command decode, setup, passcode, lights.
    always_comb begin
        logic near_hi;
        logic near_lo;
        logic los;
        logic up_p;
        logic dn_p;
        logic ent_p;
        logic go_p;
        logic in_range;
        logic fast;
        logic [11:0] step;
        logic [11:0] lo_lim;
        logic [11:0] hi_lim;
        logic [11:0] want;
        logic [15:0] ua;
        logic [15:0] tgt;
        logic [23:0] span;
        nxt_r = r_ff;
        ua = r_ff.ua2;
        los = (ua < vsu_pkg::MA_LOS_UA);
        near_hi = (ua >= vsu_pkg::MA_HIGH_UA - vsu_pkg::MA_TOL_UA) &&
                  (ua <= vsu_pkg::MA_HIGH_UA + vsu_pkg::MA_TOL_UA);
        near_lo = (ua >= vsu_pkg::MA_LOW_UA - vsu_pkg::MA_TOL_UA) &&
                  (ua <= vsu_pkg::MA_LOW_UA + vsu_pkg::MA_TOL_UA);
        up_p = r_ff.s2.up && !r_ff.prev.up;
        dn_p = r_ff.s2.down && !r_ff.prev.down;
        ent_p = r_ff.s2.enter && !r_ff.prev.enter;
        go_p = r_ff.s2.go && !r_ff.prev.go;
        tgt = r_ff.hi_side ? vsu_pkg::MA_HIGH_UA : vsu_pkg::MA_LOW_UA;
        in_range = r_ff.hi_side ? near_hi : near_lo;
        fast = (r_ff.hold_cnt >= 32'(HOLD_CYC));
        step = fast ? vsu_pkg::STEP_FAST : vsu_pkg::STEP_FINE;
        lo_lim = (r_ff.base > vsu_pkg::TRAVEL_MAX) ? r_ff.base - vsu_pkg::TRAVEL_MAX : 12'h000;
        hi_lim = r_ff.base + vsu_pkg::TRAVEL_MAX;
        want = r_ff.pos;
        span = 24'h000000;

        // Two-stage synchronisers; only stage two is read.
        nxt_r.s1 = '{STEP_UP, STEP_DOWN, ENTER_BTN, CMD_GO, RUN_SW};
        nxt_r.s2 = r_ff.s1;
        nxt_r.prev = r_ff.s2;
        nxt_r.ua1 = LOOP_UA;
        nxt_r.ua2 = r_ff.ua1;
        nxt_r.sel1 = CMD_SEL;
        nxt_r.sel2 = r_ff.sel1;
        nxt_r.adj1 = ADJUST_SETTING;
        nxt_r.adj2 = r_ff.adj1;

        // Free-running blink phase for flashing lights.
        if (r_ff.blink_cnt >= 24'(vsu_pkg::BLINK_CYC - 1)) begin
            nxt_r.blink_cnt = 24'h000000;
            nxt_r.blink = !r_ff.blink;
        end else begin
            nxt_r.blink_cnt = r_ff.blink_cnt + 24'h000001;
        end

        // Momentary effects time out on their own.
        if (r_ff.fx != FX_NONE) begin
            if (r_ff.fx_cnt >= 24'(vsu_pkg::PULSE_CYC - 1)) begin
                nxt_r.fx = FX_NONE;
            end else begin
                nxt_r.fx_cnt = r_ff.fx_cnt + 24'h000001;
            end
        end

        // Hold timer counts while either step direction is held.
        if ((r_ff.s2.up || r_ff.s2.down) && r_ff.hold_cnt <= 32'(HOLD_CYC)) begin
            nxt_r.hold_cnt = r_ff.hold_cnt + 32'h00000001;
        end else if (!(r_ff.s2.up || r_ff.s2.down)) begin
            nxt_r.hold_cnt = 32'h00000000;
        end

        // Run position re-locks the configuration.
        if (r_ff.s2.run_sw) begin
            nxt_r.locked = 1'b1; // see (RQ17)
        end

        case (r_ff.st)
            vsu_pkg::ST_IDLE: begin
                if (go_p) begin
                    nxt_r.fx_cnt = 24'h000000;
                    case (r_ff.sel2)
                        2'b00, 2'b01: begin
                            nxt_r.hi_side = (r_ff.sel2 == 2'b00);
                            if (((r_ff.sel2 == 2'b00) ? near_hi : near_lo) && // see (RQ1) see (RQ11)
                                (r_ff.adj2 != vsu_pkg::ADJ_STANDBY)) begin
                                nxt_r.st = vsu_pkg::ST_SETUP;
                                nxt_r.base = (r_ff.sel2 == 2'b00) ? r_ff.pos_max : r_ff.pos_min; // see (RQ12)
                                nxt_r.pos = nxt_r.base;
                            end else begin
                                nxt_r.fx = FX_NUMBERED; // see (RQ2)
                            end
                        end
                        2'b10: begin
                            if (r_ff.locked) begin
                                nxt_r.st = vsu_pkg::ST_CODE;
                                nxt_r.digit_n = 2'b00;
                                nxt_r.digit = 4'h0;
                                nxt_r.code = 16'h0000;
                            end else begin
                                nxt_r.fx = FX_NUMBERED; // see (RQ14)
                            end
                        end
                        default: begin
                            nxt_r.fx = FX_NONE;
                        end
                    endcase
                end
            end
            vsu_pkg::ST_SETUP: begin
                // A fast step fires as the hold time runs out, then once per blink half period.
                if (up_p || dn_p || (fast && (r_ff.s2.up || r_ff.s2.down) &&
                    (r_ff.blink_cnt == 24'h000000 || r_ff.hold_cnt == 32'(HOLD_CYC)))) begin
                    if (r_ff.adj2 == vsu_pkg::ADJ_INDEX) begin
                        nxt_r.fx = FX_NUMBERED; // see (RQ18)
                        nxt_r.fx_cnt = 24'h000000;
                    end else if (r_ff.adj2 == vsu_pkg::ADJ_ADJUST && !los && in_range) begin
                        // Step then clamp to the travel window.
                        want = r_ff.s2.up ? r_ff.pos + step : r_ff.pos - step; // see (RQ4) see (RQ5)
                        if (r_ff.s2.up && want >= hi_lim) begin
                            want = hi_lim; // see (RQ7)
                            nxt_r.fx = FX_ALL_ON; // see (RQ8)
                            nxt_r.fx_cnt = 24'h000000;
                        end else if (!r_ff.s2.up && (r_ff.pos < lo_lim + step || want <= lo_lim)) begin
                            want = lo_lim; // see (RQ7)
                            nxt_r.fx = FX_ALL_ON; // see (RQ8)
                            nxt_r.fx_cnt = 24'h000000;
                        end
                        nxt_r.pos = want;
                    end
                end
                if (ent_p) begin
                    // Store the adjusted end point and acknowledge.
                    if (r_ff.hi_side) begin
                        nxt_r.pos_max = r_ff.pos; // see (RQ6)
                    end else begin
                        nxt_r.pos_min = r_ff.pos;
                    end
                    nxt_r.fx = FX_ACK; // see (RQ6)
                    nxt_r.fx_cnt = 24'h000000;
                    nxt_r.st = vsu_pkg::ST_IDLE;
                end
            end
            vsu_pkg::ST_CODE: begin
                // Operator picks a digit, Enter confirms it.
                if (up_p) begin
                    nxt_r.digit = (r_ff.digit == 4'h9) ? 4'h0 : r_ff.digit + 4'h1; // see (RQ15)
                end else if (dn_p) begin
                    nxt_r.digit = (r_ff.digit == 4'h0) ? 4'h9 : r_ff.digit - 4'h1;
                end
                if (ent_p) begin
                    nxt_r.code = {r_ff.code[11:0], r_ff.digit};
                    nxt_r.digit = 4'h0;
                    nxt_r.digit_n = r_ff.digit_n + 2'b01;
                    if (r_ff.digit_n == 2'b11) begin
                        nxt_r.st = vsu_pkg::ST_IDLE;
                        if ({r_ff.code[11:0], r_ff.digit} == vsu_pkg::PASSCODE) begin
                            nxt_r.locked = r_ff.s2.run_sw; // see (RQ16)
                        end else begin
                            nxt_r.locked = 1'b1; // see (RQ20)
                        end
                    end
                end
            end
            default: begin
                nxt_r.st = vsu_pkg::ST_IDLE;
            end
        endcase

        // Rebuild the linear ramp from the stored end points.
        for (int i = 0; i <= vsu_pkg::IDX_MAX; i++) begin
            span = 24'(nxt_r.pos_max - nxt_r.pos_min) * 24'(i);
            nxt_r.ramp[i*12 +: 12] = nxt_r.pos_min + 12'(span / 24'(vsu_pkg::IDX_MAX)); // see (RQ10)
        end

        // Positioning is held off on signal loss, drift, or index setting.
        if (r_ff.st == vsu_pkg::ST_SETUP) begin
            if (!los && in_range && r_ff.adj2 != vsu_pkg::ADJ_INDEX) begin // see (RQ9) see (RQ18)
                nxt_r.valve = nxt_r.pos;
            end
        end
    end

    // ****************************************************************
    // State register.
    // ****************************************************************

    // Clock enable freezes all registered state except the reset release flops.
    always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            r_ff <= '0;
            r_ff.locked <= 1'b1;
            r_ff.pos_min <= vsu_pkg::POS_MIN_RST;
            r_ff.pos_max <= vsu_pkg::POS_MAX_RST;
            r_ff.st <= vsu_pkg::ST_IDLE;
            r_ff.fx <= FX_NONE;
        end else if (CLK_EN) begin
            r_ff <= nxt_r;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************

    logic los_now; // Input below the loss threshold.
    logic drift; // Input off target during setup.
    assign los_now = (r_ff.ua2 < vsu_pkg::MA_LOS_UA);
    assign drift = (r_ff.st == vsu_pkg::ST_SETUP) &&
                   ((r_ff.hi_side && ((r_ff.ua2 < vsu_pkg::MA_HIGH_UA - vsu_pkg::MA_TOL_UA) ||
                                      (r_ff.ua2 > vsu_pkg::MA_HIGH_UA + vsu_pkg::MA_TOL_UA))) ||
                    (!r_ff.hi_side && ((r_ff.ua2 < vsu_pkg::MA_LOW_UA - vsu_pkg::MA_TOL_UA) ||
                                       (r_ff.ua2 > vsu_pkg::MA_LOW_UA + vsu_pkg::MA_TOL_UA))));

    // Lights: base picture, then momentary effects on top.
    always_comb begin
        INDEX_LED = 10'h000;
        MANUAL_LED = 1'b0;
        RUN_LED = 1'b0;
        SET_A_LED = 1'b1;
        if (r_ff.st == vsu_pkg::ST_SETUP) begin
            MANUAL_LED = r_ff.blink; // see (RQ3)
            RUN_LED = r_ff.blink; // see (RQ3)
            INDEX_LED = r_ff.hi_side ? {r_ff.blink, 9'h000} : {9'h000, r_ff.blink};
        end else if (r_ff.st == vsu_pkg::ST_CODE) begin
            INDEX_LED = 10'h001 << r_ff.digit;
        end
        case (r_ff.fx)
            FX_NUMBERED: INDEX_LED = {10{r_ff.blink}}; // see (RQ2)
            FX_ALL_ON: INDEX_LED = 10'h3FF; // see (RQ8)
            FX_ACK: begin
                INDEX_LED = 10'h000; // see (RQ6)
                SET_A_LED = 1'b0;
            end
            default: INDEX_LED = INDEX_LED;
        endcase
        if (los_now) begin
            INDEX_LED = 10'h000; // see (RQ19)
        end
    end

    assign ALARM_LED = r_ff.locked ? r_ff.blink : OTHER_ALARM; // see (RQ13) see (RQ16)
    assign POS_INHIBIT = los_now || drift || (r_ff.adj2 == vsu_pkg::ADJ_INDEX); // see (RQ19) see (RQ9)
    assign VALVE_POS = r_ff.valve;
    assign LOCKED = r_ff.locked;
    assign RAMP_TABLE = r_ff.ramp;

endmodule

// >>> tb/vsu_panel_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Operator panel: one press at a time, then a release gap.
// ****************************************************************
module vsu_panel_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic [1:0] kind,
    input wire logic [7:0] len,
    output logic busy,
    output logic up,
    output logic down,
    output logic enter,
    output logic go
);
    logic [8:0] cnt_ff; // Cycles left in the current phase.
    logic gap_ff; // High while the button is released again.
    // Holds a button for len plus one cycles, then leaves it low for nine cycles.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            gap_ff <= 1'b0;
            cnt_ff <= 9'h000;
            {up, down, enter, go} <= 4'h0;
        end else if (!busy) begin
            if (req) begin
                busy <= 1'b1;
                cnt_ff <= {1'b0, len};
                {up, down, enter, go} <= 4'h8 >> kind;
            end
        end else if (cnt_ff != 9'h000) begin
            cnt_ff <= cnt_ff - 9'h001;
        end else if (!gap_ff) begin
            gap_ff <= 1'b1;
            cnt_ff <= 9'h008;
            {up, down, enter, go} <= 4'h0;
        end else begin
            gap_ff <= 1'b0;
            busy <= 1'b0;
        end
    end
endmodule

// >>> tb/vsu_ctrl_checker.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the setup and unlock logic.
// ****************************************************************
module vsu_ctrl_checker (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic [15:0] LOOP_UA,
    input wire logic RUN_SW,
    input wire logic OTHER_ALARM,
    input wire logic [11:0] VALVE_POS,
    input wire logic POS_INHIBIT,
    input wire logic [9:0] INDEX_LED,
    input wire logic ALARM_LED,
    input wire logic LOCKED,
    input wire logic [119:0] RAMP_TABLE
);
    logic alarm_q_ff; // Alarm light one cycle ago.
    logic [24:0] still_ff; // Cycles the alarm light kept its level while locked.
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // Counts how long the alarm light stands still while locked.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            alarm_q_ff <= 1'b0;
            still_ff <= 25'h0000000;
        end else begin
            alarm_q_ff <= ALARM_LED;
            still_ff <= (LOCKED && CLK_EN && ALARM_LED == alarm_q_ff) ? still_ff + 25'h0000001 : 25'h0000000;
        end
    end
    AST_RESET_LOCKED: assert property ($rose(RST_N) |-> LOCKED)
        else $error("unit not locked after reset");
    AST_ALARM_BLINK: assert property (still_ff <= 2 * vsu_pkg::BLINK_CYC + 8)
        else $error("alarm light stopped flashing while locked");
    AST_UNLOCKED_DARK: assert property ((!LOCKED && !OTHER_ALARM && CLK_EN)[*4] |-> !ALARM_LED)
        else $error("alarm light on while unlocked without alarm");
    AST_LOS_INHIBIT: assert property ((LOOP_UA < vsu_pkg::MA_LOS_UA && CLK_EN)[*5] |-> POS_INHIBIT)
        else $error("no inhibit on lost loop signal");
    AST_LOS_DARK: assert property ((LOOP_UA < vsu_pkg::MA_LOS_UA && CLK_EN)[*5] |-> INDEX_LED == 10'h000)
        else $error("index lights lit on lost loop signal");
    AST_INHIBIT_STILL: assert property (POS_INHIBIT[*2] |-> $stable(VALVE_POS))
        else $error("valve moved while inhibited");
    AST_RUN_RELOCK: assert property ((RUN_SW && CLK_EN)[*6] |-> LOCKED)
        else $error("run position did not lock the unit");
    AST_UNLOCK_NO_RUN: assert property ($fell(LOCKED) |-> !RUN_SW)
        else $error("unit unlocked in run position");
    cover property ($fell(LOCKED));
    cover property ($rose(POS_INHIBIT));
    cover property ($changed(RAMP_TABLE));
endmodule

// >>> tb/vsu_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("CHECK FAILED %0t: %s", $time, m); end end
// ****************************************************************
// Bench: unlock, relock, set-max, set-min and lost signal.
// ****************************************************************
module vsu_ctrl_tb;
    logic sys_clk = 1'b0; // 20 MHz clock.
    logic rst_n = 1'b0; // Reset, active low.
    logic req = 1'b0; // Press request to the panel.
    logic [1:0] kind = 2'h0; // 0 up, 1 down, 2 enter, 3 go.
    logic [7:0] len = 8'h04; // Press length in cycles, less one.
    logic [15:0] loop_ua = 16'h0000; // Loop current.
    logic [1:0] cmd_sel = 2'h3; // Selected command.
    logic [1:0] adjust_setting = 2'h1; // Adjustment switch.
    logic run_sw = 1'b0; // Command switch in run.
    logic busy, up, down, enter, go, pos_inhibit, manual_led, run_led, alarm_led, set_a_led, locked;
    logic [11:0] valve_pos;
    logic [9:0] index_led;
    logic [119:0] ramp;
    int n_errors = 0;
    int cmp_count = 0;
    localparam logic [11:0] TOP = vsu_pkg::POS_MAX_RST + vsu_pkg::TRAVEL_MAX; // Highest reachable max.
    always #25 sys_clk = ~sys_clk;
    vsu_panel_model pnl (.clk(sys_clk), .rst_n(rst_n), .req(req), .kind(kind), .len(len), .busy(busy),
        .up(up), .down(down), .enter(enter), .go(go));
    vsu_ctrl #(.HOLD_CYC(50)) uut (.SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(1'b1), .LOOP_UA(loop_ua),
        .CMD_GO(go), .CMD_SEL(cmd_sel), .ADJUST_SETTING(adjust_setting), .STEP_UP(up), .STEP_DOWN(down),
        .ENTER_BTN(enter), .RUN_SW(run_sw), .OTHER_ALARM(1'b0), .VALVE_POS(valve_pos),
        .POS_INHIBIT(pos_inhibit), .INDEX_LED(index_led), .MANUAL_LED(manual_led), .RUN_LED(run_led),
        .ALARM_LED(alarm_led), .SET_A_LED(set_a_led), .LOCKED(locked), .RAMP_TABLE(ramp));
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Hands one press to the panel and waits, bounded, until it is over.
    task automatic press(input logic [1:0] k, input logic [7:0] n);
        int w;
        @(posedge sys_clk);
        req <= 1'b1;
        kind <= k;
        len <= n;
        @(posedge sys_clk);
        req <= 1'b0;
        w = 0;
        #1;
        while (busy !== 1'b0 && w < 400) begin
            @(posedge sys_clk);
            #1;
            w++;
        end
        `CHK(w < 400, 1'b1, "panel press hung")
    endtask
    task automatic command(input logic [1:0] c);
        @(posedge sys_clk);
        cmd_sel <= c;
        press(2'h3, 8'h04);
        tick(4);
    endtask
    // Enters four digits, most significant first, counting up from zero.
    task automatic code(input logic [15:0] c);
        for (int d = 3; d >= 0; d--) begin
            repeat (c[4*d+:4]) press(2'h0, 8'h04);
            press(2'h2, 8'h04);
        end
        tick(4);
    endtask
    // Waits, bounded, for a ramp entry to reach its value.
    task automatic chk_ramp(input int i, input logic [11:0] e);
        int w;
        w = 0;
        while (ramp[12*i+:12] !== e && w < 300) begin
            tick(1);
            w++;
        end
        `CHK(ramp[12*i+:12], e, "ramp entry")
    endtask
    task automatic t_unlock;
        `CHK(locked, 1'b1, "locked after reset")
        chk_ramp(9, vsu_pkg::POS_MAX_RST);
        code_cmd(16'h0000);
        `CHK(locked, 1'b1, "wrong code unlocked")
        code_cmd(vsu_pkg::PASSCODE);
        `CHK(locked, 1'b0, "right code refused")
        `CHK(alarm_led, 1'b0, "alarm light on")
        command(vsu_pkg::CMD_UNLOCK);
        `CHK(locked, 1'b0, "second unlock changed lock")
    endtask
    task automatic code_cmd(input logic [15:0] c);
        command(vsu_pkg::CMD_UNLOCK);
        code(c);
    endtask
    task automatic t_relock;
        run_sw <= 1'b1;
        tick(10);
        `CHK(locked, 1'b1, "run did not lock")
        run_sw <= 1'b0;
        tick(6);
        code_cmd(vsu_pkg::PASSCODE);
    endtask
    task automatic t_setmax;
        loop_ua <= vsu_pkg::MA_HIGH_UA - vsu_pkg::MA_TOL_UA - 16'h0001;
        command(vsu_pkg::CMD_SET_MAX);
        press(2'h0, 8'h04);
        press(2'h2, 8'h04);
        chk_ramp(9, vsu_pkg::POS_MAX_RST);
        loop_ua <= vsu_pkg::MA_HIGH_UA;
        adjust_setting <= vsu_pkg::ADJ_STANDBY;
        command(vsu_pkg::CMD_SET_MAX);
        press(2'h0, 8'h04);
        press(2'h2, 8'h04);
        chk_ramp(9, vsu_pkg::POS_MAX_RST);
        adjust_setting <= vsu_pkg::ADJ_ADJUST;
        loop_ua <= vsu_pkg::MA_HIGH_UA - vsu_pkg::MA_TOL_UA;
        command(vsu_pkg::CMD_SET_MAX);
        `CHK(valve_pos, vsu_pkg::POS_MAX_RST, "setup start position")
        press(2'h0, 8'h04);
        `CHK(valve_pos, vsu_pkg::POS_MAX_RST + 12'h001, "fine step up")
        press(2'h1, 8'h04);
        `CHK(valve_pos, vsu_pkg::POS_MAX_RST, "fine step down")
        press(2'h0, 8'h3C);
        `CHK(valve_pos, vsu_pkg::POS_MAX_RST + vsu_pkg::STEP_FINE + vsu_pkg::STEP_FAST, "fast step")
        repeat (90) press(2'h0, 8'h04);
        `CHK(valve_pos, TOP, "travel bound")
        `CHK(index_led, 10'h3FF, "bound warning")
        loop_ua <= 16'h2710;
        tick(6);
        `CHK(pos_inhibit, 1'b1, "no inhibit off 20 mA")
        press(2'h1, 8'h04);
        `CHK(valve_pos, TOP, "moved while inhibited")
        loop_ua <= vsu_pkg::MA_HIGH_UA;
        tick(6);
        press(2'h2, 8'h04);
        `CHK(set_a_led, 1'b0, "no acknowledge")
        chk_ramp(9, TOP);
        chk_ramp(0, vsu_pkg::POS_MIN_RST);
    endtask
    task automatic t_setmin;
        loop_ua <= vsu_pkg::MA_LOW_UA + vsu_pkg::MA_TOL_UA;
        adjust_setting <= vsu_pkg::ADJ_INDEX;
        command(vsu_pkg::CMD_SET_MIN);
        press(2'h0, 8'h04);
        `CHK(valve_pos, TOP, "moved at index setting")
        adjust_setting <= vsu_pkg::ADJ_ADJUST;
        repeat (3) press(2'h0, 8'h04);
        `CHK(valve_pos, vsu_pkg::POS_MIN_RST + 12'h003, "min fine steps")
        press(2'h2, 8'h04);
        chk_ramp(0, vsu_pkg::POS_MIN_RST + 12'h003);
        chk_ramp(9, TOP);
        loop_ua <= 16'h000A;
        tick(8);
        `CHK(pos_inhibit, 1'b1, "no inhibit on lost signal")
        `CHK(index_led, 10'h000, "index lights on lost signal")
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        tick(3);
        rst_n <= 1'b1;
        tick(6);
        t_unlock();
        t_relock();
        t_setmax();
        t_setmin();
        end_of_test();
    end
    // Cuts a hang short well beyond the expected run length.
    initial begin
        #3000000;
        n_errors++;
        end_of_test();
    end
endmodule
bind vsu_ctrl vsu_ctrl_checker chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .LOOP_UA(LOOP_UA),
    .RUN_SW(RUN_SW), .OTHER_ALARM(OTHER_ALARM), .VALVE_POS(VALVE_POS), .POS_INHIBIT(POS_INHIBIT),
    .INDEX_LED(INDEX_LED), .ALARM_LED(ALARM_LED), .LOCKED(LOCKED), .RAMP_TABLE(RAMP_TABLE));
